// ---- hw/twsp_port.sv ----
`timescale 1ns/100ps
module twsp_port
    import twsp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic SCLK_I,
    input wire logic SDIO_I,
    input wire logic POWER_DOWN_PIN_I,
    output logic SDIO_O,
    output logic SDIO_OE_O,
    output logic BUSY_O
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_reg;  // Two-stage release chain
    logic rst_n;               // Internal reset

    // Assert at once, release after two clocks
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] sclk_sync_reg;  // Serial clock chain
    logic [2:0] sdio_sync_reg;  // Data line chain
    logic [2:0] pd_sync_reg;    // Power-down chain
    logic sclk_reg;             // Filtered clock level
    logic sdio_reg;             // Filtered data level
    logic pd_reg;               // Filtered power-down level
    logic sclk_rise;            // Rising edge pulse
    logic sclk_fall;            // Falling edge pulse

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_sync_reg <= 3'h7;
            sdio_sync_reg <= 3'h7;
            pd_sync_reg <= 3'h0;
        end
        else
        begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK_I};
            sdio_sync_reg <= {sdio_sync_reg[1:0], SDIO_I};
            pd_sync_reg <= {pd_sync_reg[1:0], POWER_DOWN_PIN_I};
        end
    end

    // Filtered levels update only on agreement
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_reg <= 1'b1;
            sdio_reg <= 1'b1;
            pd_reg <= 1'b0;
        end
        else
        begin
            if (sclk_sync_reg[1] == sclk_sync_reg[2])
                sclk_reg <= sclk_sync_reg[2];
            if (sdio_sync_reg[1] == sdio_sync_reg[2])
                sdio_reg <= sdio_sync_reg[2];
            if (pd_sync_reg[1] == pd_sync_reg[2])
                pd_reg <= pd_sync_reg[2];
        end
    end

    // Edges from agreeing stages against the filtered level
    assign sclk_rise = !sclk_reg && sclk_sync_reg[1] && sclk_sync_reg[2];
    assign sclk_fall = sclk_reg && !sclk_sync_reg[1] && !sclk_sync_reg[2];

    // ****************************************
    // Power-down pulse width
    // ****************************************
    logic [$clog2(PD_MIN_CYC+1)-1:0] pd_cnt_reg;  // High-time counter
    logic pd_long;                                 // Pulse long enough

    // Counts power-down high time; a long pulse also frees the line
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            pd_cnt_reg <= '0;
        else if (!pd_reg)
            pd_cnt_reg <= '0;
        else if (!pd_long)
            pd_cnt_reg <= pd_cnt_reg + 1'b1;
    end
    assign pd_long = (pd_cnt_reg == ($bits(pd_cnt_reg))'(PD_MIN_CYC));

    // ****************************************
    // Transaction watchdog
    // ****************************************
    logic [$clog2(WDOG_CYC+1)-1:0] wdog_cnt_reg;  // Time since first edge
    logic wdog_expired;                             // Stalled transaction
    twsp_state_type state_reg;                      // Port state
    twsp_state_type state_next;                     // Next port state

    // Runs from the first clock edge of a frame until it ends
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            wdog_cnt_reg <= '0;
        else if (state_reg == TWSP_IDLE_ST || pd_reg)
            wdog_cnt_reg <= '0;
        else if (!wdog_expired)
            wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
    end
    assign wdog_expired = (wdog_cnt_reg == ($bits(wdog_cnt_reg))'(WDOG_CYC));

    // ****************************************
    // Framing
    // ****************************************
    twsp_reg_if rif();
    logic [4:0] bit_cnt_reg;   // Rising edges seen in frame
    logic [7:0] shift_reg;     // Shift register, MSB first
    logic [6:0] addr_reg;      // Captured address
    logic port_reset;          // Resync from power-down or watchdog
    logic wr_stb_reg;          // Register write strobe

    // Power-down high or timeout returns the port to idle
    assign port_reset = pd_reg || wdog_expired;

    // Next state on serial clock edges
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            TWSP_IDLE_ST:
                // Only host clock edges open a frame
                if (sclk_fall || sclk_rise)
                    state_next = TWSP_ADDR_ST;
            TWSP_ADDR_ST:
                if (sclk_rise && bit_cnt_reg == ADDR_LAST - 5'h01)
                    state_next = (shift_reg[6] == DIR_WRITE) ? TWSP_WDATA_ST
                                                             : TWSP_RDATA_ST;
            TWSP_WDATA_ST:
                if (sclk_rise && bit_cnt_reg == FRAME_LAST - 5'h01)
                    state_next = TWSP_IDLE_ST;
            TWSP_RDATA_ST:
                // Frame ends on the falling edge after the last bit
                if (sclk_fall && bit_cnt_reg == FRAME_LAST)
                    state_next = TWSP_IDLE_ST;
            default:
                state_next = TWSP_IDLE_ST;
        endcase
    end

    // State register
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= TWSP_IDLE_ST;
        else if (port_reset)
            state_reg <= TWSP_IDLE_ST;
        else
            state_reg <= state_next;
    end

    // Bit counter counts rising edges of the frame
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            bit_cnt_reg <= BIT_CNT_RESET;
        else if (port_reset || state_next == TWSP_IDLE_ST)
            bit_cnt_reg <= BIT_CNT_RESET;
        else if (sclk_rise)
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end

    // Shift in on rising edges, MSB first
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            shift_reg <= 8'h00;
        else if (port_reset)
            shift_reg <= 8'h00;
        else if (sclk_rise && state_reg != TWSP_RDATA_ST)
            shift_reg <= {shift_reg[6:0], sdio_reg};
        else if (state_reg == TWSP_RDATA_ST && sclk_rise)
            shift_reg <= {shift_reg[6:0], 1'b0};
    end

    // Capture address at end of first byte
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            addr_reg <= 7'h00;
        else if (sclk_rise && state_reg == TWSP_ADDR_ST && bit_cnt_reg == ADDR_LAST - 5'h01)
            addr_reg <= {shift_reg[5:0], sdio_reg};
    end

    // Write strobe after sixteenth rising edge; never on a reset
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            wr_stb_reg <= 1'b0;
        else
            wr_stb_reg <= !port_reset && sclk_rise && state_reg == TWSP_WDATA_ST
                          && bit_cnt_reg == FRAME_LAST - 5'h01;
    end

    assign rif.addr = addr_reg;
    assign rif.wdata = shift_reg;
    assign rif.wr_stb = wr_stb_reg;

    // ****************************************
    // Read data driver
    // ****************************************
    logic [7:0] out_reg;   // Outgoing data bits
    logic oe_reg;          // Pin driven by this device
    logic sdo_reg;         // Pin output level

    // Load once the read address is known; shift on later falling edges
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_reg <= 8'h00;
            oe_reg <= 1'b0;
            sdo_reg <= 1'b0;
        end
        else if (pd_long || port_reset)
        begin
            oe_reg <= 1'b0;
            sdo_reg <= 1'b0;
        end
        else if (state_reg == TWSP_RDATA_ST)
        begin
            if (bit_cnt_reg == ADDR_LAST && !oe_reg)
            begin
                // First read cycle: D7 must stand before the host's next rise
                out_reg <= {rif.rdata[6:0], 1'b0};
                sdo_reg <= rif.rdata[7];
                oe_reg <= 1'b1;
            end
            else if (sclk_fall && bit_cnt_reg == FRAME_LAST)
                oe_reg <= 1'b0;
            // The fall ahead of the ninth rise keeps D7 on the line
            else if (sclk_fall && oe_reg && bit_cnt_reg != ADDR_LAST)
            begin
                sdo_reg <= out_reg[7];
                out_reg <= {out_reg[6:0], 1'b0};
            end
        end
        else
            oe_reg <= 1'b0;
    end

    assign SDIO_O = sdo_reg;
    assign SDIO_OE_O = oe_reg;
    assign BUSY_O = (state_reg != TWSP_IDLE_ST);

    // ****************************************
    // Register file
    // ****************************************
    twsp_regs #(
        .NUM_REGS(18)
    ) u_regs (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .bus(rif.regs)
    );

endmodule

// ---- inc/twsp_pkg.sv ----
package twsp_pkg;

    // Core clock rate and period in picoseconds
    localparam int CLK_HZ = 25000000;
    localparam longint CLK_PS = 40000;

    // Power-down pulse length that sets pd_long; a shorter pulse also resynchronises the port
    localparam longint PD_MIN_US = 100;
    localparam int PD_MIN_CYC = int'((PD_MIN_US * 1000000 + CLK_PS - 1) / CLK_PS);

    // Transaction watchdog, typical figure in milliseconds
    localparam longint WDOG_MS = 900;
    localparam int WDOG_CYC = int'((WDOG_MS * 1000000000) / CLK_PS);

    // Frame layout
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] BIT_CNT_RESET = 5'h00;
    localparam logic [4:0] ADDR_LAST = 5'h08;
    localparam logic [4:0] FRAME_LAST = 5'h10;

    // Direction bit values in the address byte
    localparam logic DIR_WRITE = 1'b1;
    localparam logic DIR_READ = 1'b0;

    // Port sequencing states
    typedef enum logic [3:0]
    {
        TWSP_IDLE_ST = 4'b0001,
        TWSP_ADDR_ST = 4'b0010,
        TWSP_WDATA_ST = 4'b0100,
        TWSP_RDATA_ST = 4'b1000
    } twsp_state_type;

endpackage

// ---- inc/twsp_reg_if.sv ----
`timescale 1ns/100ps
// Register access path between the port and the register file
interface twsp_reg_if;
    logic [6:0] addr;   // Register address
    logic [7:0] wdata;  // Write data
    logic wr_stb;       // One-cycle write strobe
    logic [7:0] rdata;  // Read data, zero for unknown address
    logic hit;          // Address is implemented

    modport port
    (
        output addr,
        output wdata,
        output wr_stb,
        input rdata,
        input hit
    );
    modport regs
    (
        input addr,
        input wdata,
        input wr_stb,
        output rdata,
        output hit
    );
endinterface

// ---- hw/twsp_regs.sv ----
`timescale 1ns/100ps
// Small register file behind the serial port
module twsp_regs
    import twsp_pkg::*;
#(
    parameter int NUM_REGS = 18
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    twsp_reg_if.regs bus
);

    // Register storage, kept across a power-down resync
    logic [7:0] store_reg [NUM_REGS];

    // ****************************************
    // Storage
    // ****************************************
    // One generate entry per register
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++)
        begin : g_reg
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    store_reg[g] <= 8'h00;
                else if (bus.wr_stb && bus.addr == 7'(g))
                    store_reg[g] <= bus.wdata;
            end
        end
    endgenerate

    // Unimplemented addresses read as zero
    assign bus.hit = (bus.addr < 7'(NUM_REGS));
    assign bus.rdata = bus.hit ? store_reg[bus.addr[4:0]] : 8'h00;

endmodule

// ---- verification/twsp_port_checker.sv ----
`timescale 1ns/100ps
// ********
// Port checker
// ********
module twsp_port_checker
    import twsp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic SCLK_I,
    input wire logic SDIO_I,
    input wire logic POWER_DOWN_PIN_I,
    input wire logic SDIO_O,
    input wire logic SDIO_OE_O,
    input wire logic BUSY_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    logic sclk_prev_reg; // Last clock level
    logic [3:0] quiet_reg; // Cycles since a clock edge
    logic [11:0] pd_reg; // Power-down high run
    // Edge age, saturating so long idle never wraps
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            sclk_prev_reg <= 1'b1;
            quiet_reg <= 4'hf;
        end
        else
        begin
            sclk_prev_reg <= SCLK_I;
            if (SCLK_I != sclk_prev_reg)
                quiet_reg <= 4'h0;
            else if (quiet_reg != 4'hf)
                quiet_reg <= quiet_reg + 4'h1;
        end
    end
    // Length of the current power-down pulse
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            pd_reg <= 12'h000;
        else if (!POWER_DOWN_PIN_I)
            pd_reg <= 12'h000;
        else if (pd_reg != 12'hfff)
            pd_reg <= pd_reg + 12'h001;
    end
    a_reset_quiet: assert property ($rose(RST_N_I) |-> !SDIO_OE_O && !BUSY_O)
        else $error("port active at reset release");
    a_busy_from_edge: assert property ($rose(BUSY_O) |-> quiet_reg < 4'ha)
        else $error("frame opened without a clock edge");
    a_fall_in_frame: assert property ($fell(SCLK_I) && !POWER_DOWN_PIN_I |-> ##[1:10] BUSY_O)
        else $error("clock fall did not open a frame");
    a_oe_in_frame: assert property ($rose(SDIO_OE_O) |-> BUSY_O && SCLK_I && $past(SCLK_I, 3))
        else $error("drive began outside a read");
    a_data_steady: assert property ((SDIO_OE_O && SCLK_I && !POWER_DOWN_PIN_I) [*8]
        |=> $stable(SDIO_O) || !SDIO_OE_O) else $error("data moved while clock high");
    a_write_input: assert property ($fell(BUSY_O) && !SDIO_OE_O |-> !SDIO_OE_O [*8])
        else $error("line driven after a write");
    a_pd_idles: assert property (POWER_DOWN_PIN_I [*8] |-> !BUSY_O)
        else $error("frame alive in power-down");
    a_pd_releases: assert property (int'(pd_reg) > PD_MIN_CYC + 12 |-> !SDIO_OE_O)
        else $error("line still driven after power-down");
endmodule
bind twsp_port twsp_port_checker u_chk
(
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .SCLK_I(SCLK_I),
    .SDIO_I(SDIO_I),
    .POWER_DOWN_PIN_I(POWER_DOWN_PIN_I),
    .SDIO_O(SDIO_O),
    .SDIO_OE_O(SDIO_OE_O),
    .BUSY_O(BUSY_O)
);

// ---- verification/twsp_host_model.sv ----
`timescale 1ns/100ps
// ********
// Serial master model
// ********
module twsp_host_model
(
    input wire logic clk_i,
    input wire logic sdio_i,
    output logic sclk_o,
    output logic sdio_o,
    output logic sdio_oe_o
);
    localparam int GAP_CYC = 2500; // 100 us at 40 ns
    // Clock idles high, line released
    initial
    begin
        sclk_o = 1'b1;
        sdio_o = 1'b0;
        sdio_oe_o = 1'b0;
    end
    // Top n bits, first bit leading
    task send_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            sclk_o <= 1'b0;
            // A read's last bit may still be on the line: wait for release
            if (i == 0)
                repeat (4) @(posedge clk_i);
            sdio_oe_o <= 1'b1;
            sdio_o <= b[7 - i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask
    // Write, then the spacing a later command needs
    task wr(input logic [6:0] a, input logic [7:0] d);
        send_bits({1'b1, a}, 8);
        send_bits(d, 8);
        @(posedge clk_i);
        sdio_oe_o <= 1'b0;
        repeat (GAP_CYC) @(posedge clk_i);
    endtask
    // Read; sampled late in the high phase, clock left high
    task rd(input logic [6:0] a, output logic [7:0] d);
        send_bits({1'b0, a}, 8);
        sdio_oe_o <= 1'b0;
        repeat (GAP_CYC) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            sclk_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            d[7 - i] = sdio_i;
        end
    endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/100ps
// ********
// Port bench
// ********
module tb;
    typedef struct {logic [6:0] a; logic [7:0] w; logic [7:0] e;} twsp_row_type;
    // Address, written byte, expected readback
    twsp_row_type rows [5] = '{'{7'h00, 8'ha5, 8'ha5}, '{7'h11, 8'h3c, 8'h3c},
        '{7'h12, 8'hff, 8'h00}, '{7'h7f, 8'h81, 8'h00}, '{7'h08, 8'h01, 8'h01}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pd = 1'b0;
    logic flt = 1'b0; // Floating line stand-in
    logic [7:0] rv;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    wire sclk, h_d, h_oe, d_o, d_oe, busy;
    // Released line changes each cycle, never a stale value
    wire sdio = d_oe ? d_o : (h_oe ? h_d : flt);
    twsp_port DUT
    (
        .CLK_I(clk),
        .RST_N_I(rst_n),
        .SCLK_I(sclk),
        .SDIO_I(sdio),
        .POWER_DOWN_PIN_I(pd),
        .SDIO_O(d_o),
        .SDIO_OE_O(d_oe),
        .BUSY_O(busy)
    );
    twsp_host_model u_host
    (
        .clk_i(clk),
        .sdio_i(sdio),
        .sclk_o(sclk),
        .sdio_o(h_d),
        .sdio_oe_o(h_oe)
    );
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        flt <= ~flt;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard, well above the expected run
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            err_count++;
            test_done;
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        check({5'h00, d_oe, d_o, busy}, 8'h00);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Write then read back each row
        foreach (rows[i])
        begin
            u_host.wr(rows[i].a, rows[i].w);
            check({7'h00, busy}, 8'h00);
            u_host.rd(rows[i].a, rv);
            check(rv, rows[i].e);
            check({6'h00, d_oe, d_o}, {7'h01, rows[i].e[0]});
        end
        // Power-down frees the line left driven by a read
        pd <= 1'b1;
        repeat (2520) @(posedge clk);
        check({7'h00, d_oe}, 8'h00);
        pd <= 1'b0;
        repeat (10) @(posedge clk);
        // Write to 0x00 cut short must not land
        u_host.send_bits(8'h80, 8);
        u_host.send_bits(8'hee, 4);
        pd <= 1'b1;
        repeat (2520) @(posedge clk);
        pd <= 1'b0;
        repeat (10) @(posedge clk);
        u_host.rd(7'h00, rv);
        check(rv, 8'ha5);
        // Reset in mid-read drops the line and clears the registers
        u_host.send_bits(8'h00, 8);
        u_host.sdio_oe_o <= 1'b0;
        repeat (8) @(posedge clk);
        check({6'h00, d_oe, d_o}, 8'h03);
        rst_n <= 1'b0;
        @(posedge clk);
        check({6'h00, d_oe, busy}, 8'h00);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        u_host.rd(7'h00, rv);
        check(rv, 8'h00);
        test_done;
    end
endmodule
